// *** rtl/rsq_pkg.sv ***
// Shared constants for the reset sequencer
package rsq_pkg;
   localparam int          RSQ_PC_W        = 10;
   localparam logic [9:0]  RSQ_START_ADDR  = 10'h000;
   localparam int          RSQ_STAGE_W     = 8;
   localparam logic [7:0]  RSQ_STAGE_MAX   = 8'hFF;
   localparam int          RSQ_WAIT_CYCLES = 256 * 256;
   localparam int          RSQ_SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      RSQ_HELD,
      RSQ_WAIT,
      RSQ_RUN
   } rsq_state_e;
endpackage

// *** rtl/rsq_stage_cnt.sv ***
// One eight-bit stage of the stabilisation counter
`timescale 1ns/1ps
module rsq_stage_cnt (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       clr,
   input  wire logic       inc,
   output logic [7:0]      cnt_ff,
   output logic            wrap
);
   import rsq_pkg::*;

   // Wrap marks the last count of this stage
   assign wrap = inc && (cnt_ff == RSQ_STAGE_MAX);

   // Count up, held at zero while cleared
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= 8'h00;
      end else if (clr) begin
         cnt_ff <= 8'h00;
      end else if (inc) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule // rsq_stage_cnt

// *** rtl/rsq_sequencer.sv ***
// Reset sequencer with oscillation stabilisation wait
`timescale 1ns/1ps
// Overview of operation
// - Pin reset leaves the clock running; its release runs the timer wait, then fetch starts at 0000H.
// - The wait lasts until the timer has counted 256 x 256 system clocks.
// - Power-on reset runs the same wait and start as a pin reset, and also stops the oscillator.
// - A stack overflow or underflow restarts at 0000H at once, with no wait.
// - The power-on detector holds the device in reset whether or not the clock runs.
// - The oscillator stays stopped while a power-on or power-down reset stands.
// - After power-on reset ends the timer counts clock pulses to the wait value.
// - After power-down reset and the wait, execution starts from the first location.
// - Power-down reset acts only while software has set its enable flag.
// - A detected supply drop holds reset continuously until the supply recovers.
// - On rising from zero volts the power-on reset takes precedence.
module rsq_sequencer (
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   input  wire logic                     ext_reset_n,
   input  wire logic                     por_active,
   input  wire logic                     supply_low,
   input  wire logic                     brownout_reset_enable,
   input  wire logic                     stack_fault,
   output logic                          osc_run_ff,
   output logic                          core_reset_ff,
   output logic                          pc_load_ff,
   output logic [rsq_pkg::RSQ_PC_W-1:0]  pc_start_ff,
   output logic                          wait_busy_ff,
   output logic                          brownout_active_ff,
   output logic                          power_reset_ff
);
   import rsq_pkg::*;

   rsq_state_e state_ff;
   rsq_state_e nxt_state;
   logic       bod_hold;
   logic       pwr_rst;
   logic       hold_rst;
   logic       cnt_clr;
   logic       cnt_inc;
   logic [7:0] lo_cnt;
   logic [7:0] hi_cnt;
   logic       lo_wrap;
   logic       hi_wrap;
   logic       wait_done;
   logic       in_wait;
   logic       in_run;
   logic       run_entry;
   logic       stack_kick;
   logic       nxt_osc_run;
   logic       nxt_core_reset;
   logic       nxt_pc_load;
   logic       nxt_wait_busy;
   logic       nxt_brownout_active;
   logic       nxt_power_reset;

   // Brown-out reset acts only when enabled, stays while supply low
   assign bod_hold = brownout_reset_enable && supply_low;
   // Power-on has precedence; either power source counts as a power reset
   assign pwr_rst  = por_active || bod_hold;
   // All holding sources combined
   assign hold_rst = pwr_rst || !ext_reset_n;

   // Wait finishes when the high byte wraps
   assign wait_done = hi_wrap;

   // Decoded state of the sequence
   assign in_wait = (state_ff == RSQ_WAIT);
   assign in_run  = (state_ff == RSQ_RUN);

   // Clean end of the wait into run
   assign run_entry  = in_wait && wait_done && !hold_rst;
   // Stack fault acts only while running and not held
   assign stack_kick = in_run && stack_fault && !hold_rst;

   // Counter held clear while any source holds or outside the wait
   always_comb begin
      cnt_clr = 1'b1;
      if (in_wait && !hold_rst) begin
         cnt_clr = 1'b0;
      end
   end

   // Low byte steps every wait cycle
   assign cnt_inc = !cnt_clr;

   // Low byte of the 256 x 256 timer
   rsq_stage_cnt u_lo (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .clr     (cnt_clr),
      .inc     (cnt_inc),
      .cnt_ff  (lo_cnt),
      .wrap    (lo_wrap)
   );

   // High byte advances on each low wrap
   rsq_stage_cnt u_hi (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .clr     (cnt_clr),
      .inc     (lo_wrap),
      .cnt_ff  (hi_cnt),
      .wrap    (hi_wrap)
   );

   // Next state of the sequence
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         RSQ_HELD: begin
            if (!hold_rst) begin
               nxt_state = RSQ_WAIT;
            end
         end
         RSQ_WAIT: begin
            if (hold_rst) begin
               nxt_state = RSQ_HELD;
            end else if (wait_done) begin
               nxt_state = RSQ_RUN;
            end
         end
         RSQ_RUN: begin
            if (hold_rst) begin
               nxt_state = RSQ_HELD;
            end
         end
         default: begin
            nxt_state = RSQ_HELD;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= RSQ_HELD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Oscillator stopped while a power reset stands
   always_comb begin
      nxt_osc_run = 1'b1;
      if (pwr_rst) begin
         nxt_osc_run = 1'b0;
      end
   end

   // Core held outside run and for one cycle on a stack restart
   always_comb begin
      nxt_core_reset = 1'b0;
      if (nxt_state != RSQ_RUN) begin
         nxt_core_reset = 1'b1;
      end else if (stack_kick) begin
         nxt_core_reset = 1'b1;
      end
   end

   // Start-address load at the end of the wait or on a stack restart
   always_comb begin
      nxt_pc_load = 1'b0;
      if (run_entry) begin
         nxt_pc_load = 1'b1;
      end else if (stack_kick) begin
         nxt_pc_load = 1'b1;
      end
   end

   // Busy for the whole stabilisation wait
   always_comb begin
      nxt_wait_busy = 1'b0;
      if (nxt_state == RSQ_WAIT) begin
         nxt_wait_busy = 1'b1;
      end
   end

   // Brown-out status yields to power-on
   always_comb begin
      nxt_brownout_active = 1'b0;
      if (bod_hold && !por_active) begin
         nxt_brownout_active = 1'b1;
      end
   end

   // Either power source reports a power reset
   always_comb begin
      nxt_power_reset = 1'b0;
      if (pwr_rst) begin
         nxt_power_reset = 1'b1;
      end
   end

   // Oscillator stopped during power resets
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         osc_run_ff <= 1'b0;
      end else begin
         osc_run_ff <= nxt_osc_run;
      end
   end

   // Core held until run; stack fault gives one reset cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         core_reset_ff <= 1'b1;
      end else begin
         core_reset_ff <= nxt_core_reset;
      end
   end

   // Start-address load pulse at every entry to run
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc_load_ff <= 1'b0;
      end else begin
         pc_load_ff <= nxt_pc_load;
      end
   end

   // Start address is fixed at zero
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc_start_ff <= RSQ_START_ADDR;
      end else begin
         pc_start_ff <= RSQ_START_ADDR;
      end
   end

   // Wait status
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wait_busy_ff <= 1'b0;
      end else begin
         wait_busy_ff <= nxt_wait_busy;
      end
   end

   // Brown-out status
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         brownout_active_ff <= 1'b0;
      end else begin
         brownout_active_ff <= nxt_brownout_active;
      end
   end

   // Power reset status
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         power_reset_ff <= 1'b0;
      end else begin
         power_reset_ff <= nxt_power_reset;
      end
   end
endmodule // rsq_sequencer

// *** test/rsq_properties.sv ***
// Port checker for the reset sequencer
`timescale 1ns/1ps
module rsq_properties (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ext_reset_n,
   input wire logic por_active,
   input wire logic supply_low,
   input wire logic brownout_reset_enable,
   input wire logic stack_fault,
   input wire logic osc_run_ff,
   input wire logic core_reset_ff,
   input wire logic pc_load_ff,
   input wire logic [rsq_pkg::RSQ_PC_W-1:0] pc_start_ff,
   input wire logic wait_busy_ff,
   input wire logic brownout_active_ff,
   input wire logic power_reset_ff
);
   import rsq_pkg::*;
   logic [16:0] wcnt_ff;
   wire pwr  = por_active || (brownout_reset_enable && supply_low);
   wire hold = pwr || !ext_reset_n;
   // Length of the current wait
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst) wcnt_ff <= 17'h00000;
      else wcnt_ff <= wait_busy_ff ? wcnt_ff + 17'h00001 : 17'h00000;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Stack restart: reset pulse with load, then run
   sequence s_kick;
      pc_load_ff && core_reset_ff ##1 !core_reset_ff;
   endsequence
   osc_stop_a: assert property (por_active |=> !osc_run_ff) else $error("osc runs");
   core_hold_a: assert property (hold |=> core_reset_ff && !wait_busy_ff && !pc_load_ff)
      else $error("core not held");
   pd_gate_a: assert property (!brownout_reset_enable && !por_active |=> !power_reset_ff)
      else $error("brownout acts while off");
   pd_hold_a: assert property (brownout_reset_enable && supply_low |=> power_reset_ff)
      else $error("brownout dropped");
   por_first_a: assert property (por_active |=> !brownout_active_ff) else $error("por lost");
   start_addr_a: assert property (pc_load_ff |-> pc_start_ff == RSQ_START_ADDR)
      else $error("bad start");
   wait_len_a: assert property (pc_load_ff && !core_reset_ff |-> wcnt_ff >= 17'h0FFFE
      && wcnt_ff <= 17'h10002) else $error("bad wait length");
   stack_fast_a: assert property (stack_fault && !core_reset_ff && !hold |=> s_kick)
      else $error("no fast restart");
   wait_start_a: assert property ($fell(hold) |-> ##[1:2] wait_busy_ff)
      else $error("wait not started");
   osc_run_a: assert property (!pwr |=> osc_run_ff)
      else $error("osc still stopped");
   bo_flag_a: assert property (pwr && !por_active |=> brownout_active_ff)
      else $error("brownout flag missing");
endmodule // rsq_properties
bind rsq_sequencer rsq_properties u_chk (.*);

// *** test/rsq_supply.sv ***
// Supply detector and reset pin model
`timescale 1ns/1ps
module rsq_supply (
   input  wire logic vdd_on,
   input  wire logic vdd_dip,
   input  wire logic pin_hold,
   output logic      por_active,
   output logic      supply_low,
   output logic      ext_reset_n
);
   // Detector levels follow the supply
   assign por_active  = !vdd_on;
   assign supply_low  = vdd_dip || !vdd_on;
   assign ext_reset_n = !pin_hold;
endmodule // rsq_supply

// *** test/testbench.sv ***
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module testbench;
   import rsq_pkg::*;
   logic ref_clk = 0, nrst = 0, vdd_on = 0, vdd_dip = 0, pin_hold = 0, en = 0, sf = 0;
   logic por, low, ext_n, osc, crst, ld, busy, bo, pr;
   logic [RSQ_PC_W-1:0] pc;
   int fails = 0, checked = 0;
   always #50 ref_clk = ~ref_clk;
   rsq_supply u_sup (.vdd_on, .vdd_dip, .pin_hold, .por_active(por), .supply_low(low),
      .ext_reset_n(ext_n));
   rsq_sequencer u_dut (.ref_clk, .nrst, .ext_reset_n(ext_n), .por_active(por),
      .supply_low(low), .brownout_reset_enable(en), .stack_fault(sf), .osc_run_ff(osc),
      .core_reset_ff(crst), .pc_load_ff(ld), .pc_start_ff(pc), .wait_busy_ff(busy),
      .brownout_active_ff(bo), .power_reset_ff(pr));
   task automatic chk(string n, logic [9:0] e, logic [9:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask
   task automatic give_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Power-on release, full wait, start at zero
   task automatic power_up;
      int c = 0;
      chk("osc", 0, osc);
      chk("crst", 1, crst);
      vdd_on = 1;
      step(2);
      chk("busy", 1, busy);
      chk("osc", 1, osc);
      while (ld !== 1'b1 && c < 70000) begin
         step(1);
         c++;
      end
      chk("wait", 1, c + 2 >= RSQ_WAIT_CYCLES && c <= RSQ_WAIT_CYCLES + 2);
      chk("run", 0, crst);
      chk("pc", RSQ_START_ADDR, pc);
   endtask
   // Stack fault restarts with no wait
   task automatic stack_hit;
      sf = 1;
      step(1);
      sf = 0;
      chk("ld", 1, ld);
      step(2);
      chk("crst", 0, crst);
      chk("busy", 0, busy);
   endtask
   // Brown-out gated by enable, then pin reset and POR priority
   task automatic droop;
      vdd_dip = 1;
      step(3);
      chk("pr", 0, pr);
      en = 1;
      step(2);
      chk("pr", 1, pr);
      chk("osc", 0, osc);
      chk("bo", 1, bo);
      vdd_dip = 0;
      step(3);
      chk("busy", 1, busy);
      chk("osc", 1, osc);
      pin_hold = 1;
      step(2);
      chk("busy", 0, busy);
      chk("crst", 1, crst);
      vdd_on = 0;
      step(2);
      chk("bo", 0, bo);
      chk("pr", 1, pr);
      chk("osc", 0, osc);
   endtask
   initial begin
      step(16);
      nrst = 1;
      step(2);
      power_up;
      stack_hit;
      droop;
      give_verdict;
   end
   // Watchdog
   initial begin
      repeat (80000) @(posedge ref_clk);
      fails++;
      give_verdict;
   end
endmodule // testbench
